//--- shared/adc_port_pkg.sv
package adc_port_pkg;
	// communications byte layout
	localparam int COMM_RS_MSB  = 6;
	localparam int COMM_RS_LSB  = 4;
	localparam int COMM_RW_BIT  = 3;
	localparam int COMM_CH_MSB  = 1;
	localparam int COMM_CH_LSB  = 0;
	// register selects
	localparam logic [2:0] REG_COMM  = 3'h0;
	localparam logic [2:0] REG_SETUP = 3'h1;
	localparam logic [2:0] REG_CLOCK = 3'h2;
	localparam logic [2:0] REG_DATA  = 3'h3;
	// known command codes
	localparam logic [7:0] CMD_CLOCK_WR = 8'h20;
	localparam logic [7:0] CMD_SETUP_WR = 8'h10;
	localparam logic [7:0] CMD_DATA_RD  = 8'h38;
	// setup register fields
	localparam int SETUP_CAL_MSB   = 7;
	localparam int SETUP_CAL_LSB   = 6;
	localparam int SETUP_GAIN_MSB  = 5;
	localparam int SETUP_GAIN_LSB  = 3;
	localparam int SETUP_UNIP_BIT  = 2;
	localparam int SETUP_BUF_BIT   = 1;
	localparam int SETUP_SYNC_BIT  = 0;
	localparam logic [1:0] CAL_SELF = 2'h1;
	// clock register fields
	localparam int CLK_DIS_BIT  = 4;
	localparam int CLK_DIV_BIT  = 3;
	localparam int CLK_RATE_MSB = 1;
	localparam int CLK_RATE_LSB = 0;
	// reset values
	localparam logic [7:0] SETUP_RST = 8'h01;
	localparam logic [7:0] CLOCK_RST = 8'h05;
	// serial framing
	localparam int BYTE_BITS = 8;
	localparam int DATA_BITS = 16;
	// filter settling: results discarded after a resync
	localparam int SETTLE_UPDATES = 3;
	localparam int FIFO_DEPTH     = 8;
endpackage

//--- rtl/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             do_wr, do_rd;

	////////////////////////////////////////////////////////////////
	// pointer and count update
	always_comb begin
		do_wr = in_valid && in_ready;
		do_rd = out_valid && out_ready;
		wr_d  = do_wr ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
		rd_d  = do_rd ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge core_clk) begin
		if (do_wr) begin
			mem_q[wr_q] <= in_data;
		end
	end

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
endmodule

//--- rtl/adc_serial_port.sv
`timescale 1ns/1ps
module adc_serial_port #(
	parameter int FIFO_W = 16,
	parameter int FIFO_D = 8
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe,
	output logic             conversion_ready_n,
	input  wire logic [15:0] sample_data,
	input  wire logic        sample_valid,
	output logic             sample_ready,
	output logic [1:0]       active_channel,
	output logic [7:0]       setup_reg,
	output logic [7:0]       clock_reg,
	output logic             filter_reset,
	output logic             cal_start
);
	typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} port_state_t;

	// shift by one bit, msb first
	function automatic logic [15:0] shl(input logic [15:0] v, input logic b);
		return {v[14:0], b};
	endfunction

	////////////////////////////////////////////////////////////////
	// pin synchronisers; stage one only feeds stage two
	logic [2:0] s1_q, s2_q;
	logic       sclk_prev_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s1_q        <= 3'h7;
			s2_q        <= 3'h7;
			sclk_prev_q <= 1'b1;
		end else begin
			s1_q        <= {sclk, cs_n, din};
			s2_q        <= s1_q;
			sclk_prev_q <= s2_q[2];
		end
	end
	logic sclk_s, cs_s, din_s, rise, fall;
	assign sclk_s = s2_q[2];
	assign cs_s   = s2_q[1];
	assign din_s  = s2_q[0];
	// clock idles high: shift out on falling, sample on rising
	assign rise   = !cs_s && sclk_s && !sclk_prev_q;
	assign fall   = !cs_s && !sclk_s && sclk_prev_q;

	////////////////////////////////////////////////////////////////
	// output fifo between converter and data register
	logic [15:0] fifo_data;
	logic        fifo_valid, fifo_pop;
	sample_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
		.core_clk  (core_clk),
		.srst      (srst),
		.in_data   (sample_data),
		.in_valid  (sample_valid && !filter_reset),
		.in_ready  (sample_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	////////////////////////////////////////////////////////////////
	// serial engine state
	port_state_t st_q, st_d;
	logic [15:0] sh_q, sh_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [4:0]  len_q, len_d;
	logic [2:0]  tgt_q, tgt_d;
	logic [1:0]  ch_q, ch_d;
	logic [7:0]  setup_q, setup_d, clock_q, clock_d;
	logic [15:0] data_q, data_d;
	logic        full_q, full_d;
	logic [1:0]  skip_q, skip_d;
	logic        fres_q, fres_d, cal_q, cal_d, dout_q, dout_d, oe_q, oe_d;
	logic [7:0]  byte_in;

	// next-state: command decode, register writes, data read
	always_comb begin
		st_d    = st_q;
		sh_d    = sh_q;
		cnt_d   = cnt_q;
		len_d   = len_q;
		tgt_d   = tgt_q;
		ch_d    = ch_q;
		setup_d = setup_q;
		clock_d = clock_q;
		data_d  = data_q;
		full_d  = full_q;
		skip_d  = skip_q;
		fres_d  = 1'b0;
		cal_d   = 1'b0;
		dout_d  = dout_q;
		oe_d    = oe_q;
		fifo_pop = 1'b0;
		byte_in = {sh_q[6:0], din_s};
		// move a fresh word into the data register when it is free
		if (!full_q && fifo_valid && !(st_q == ST_RD)) begin
			fifo_pop = 1'b1;
			if (skip_q != 2'h0) begin
				skip_d = skip_q - 2'h1;
			end else begin
				data_d = fifo_data;
				full_d = 1'b1;
			end
		end
		case (st_q)
			ST_CMD: begin
				oe_d = 1'b0;
				if (rise) begin
					sh_d  = shl(sh_q, din_s);
					cnt_d = cnt_q + 5'h1;
					if (cnt_q == 5'(adc_port_pkg::BYTE_BITS - 1)) begin
						cnt_d = '0;
						ch_d  = byte_in[adc_port_pkg::COMM_CH_MSB:adc_port_pkg::COMM_CH_LSB];
						tgt_d = byte_in[adc_port_pkg::COMM_RS_MSB:adc_port_pkg::COMM_RS_LSB];
						if (byte_in[adc_port_pkg::COMM_RS_MSB:adc_port_pkg::COMM_RS_LSB]
							== adc_port_pkg::REG_COMM) begin
							st_d = ST_CMD;
						end else if (byte_in[adc_port_pkg::COMM_RW_BIT]) begin
							st_d   = ST_RD;
							len_d  = (byte_in[6:4] == adc_port_pkg::REG_DATA) ?
								5'(adc_port_pkg::DATA_BITS) : 5'(adc_port_pkg::BYTE_BITS);
							// a word loaded in this same cycle must be the one read out,
							// else the read end would clear it unread
							sh_d   = (byte_in[6:4] == adc_port_pkg::REG_DATA) ? data_d :
								(byte_in[6:4] == adc_port_pkg::REG_SETUP) ? {setup_q, 8'h00} :
								(byte_in[6:4] == adc_port_pkg::REG_CLOCK) ? {clock_q, 8'h00} :
								{!full_q, 15'h0000};
							dout_d = (byte_in[6:4] == adc_port_pkg::REG_DATA) ? data_d[15] :
								(byte_in[6:4] == adc_port_pkg::REG_SETUP) ? setup_q[7] :
								(byte_in[6:4] == adc_port_pkg::REG_CLOCK) ? clock_q[7] : !full_q;
							oe_d   = 1'b1;
						end else begin
							st_d = ST_WR;
						end
					end
				end
			end
			ST_WR: begin
				if (rise) begin
					sh_d  = shl(sh_q, din_s);
					cnt_d = cnt_q + 5'h1;
					if (cnt_q == 5'(adc_port_pkg::BYTE_BITS - 1)) begin
						cnt_d = '0;
						st_d  = ST_CMD;
						if (tgt_q == adc_port_pkg::REG_SETUP) begin
							setup_d = byte_in;
							if (byte_in[adc_port_pkg::SETUP_SYNC_BIT] ||
								byte_in[adc_port_pkg::SETUP_CAL_MSB:adc_port_pkg::SETUP_CAL_LSB]
								!= 2'h0) begin
								full_d = 1'b0;
								skip_d = 2'(adc_port_pkg::SETTLE_UPDATES);
							end
							cal_d = (byte_in[7:6] == adc_port_pkg::CAL_SELF);
						end else if (tgt_q == adc_port_pkg::REG_CLOCK) begin
							clock_d = byte_in;
						end
					end
				end
			end
			ST_RD: begin
				// input bits ignored while reading
				if (fall && cnt_q != 5'h0) begin
					dout_d = sh_q[15];
				end
				if (rise) begin
					sh_d  = shl(sh_q, 1'b0);
					cnt_d = cnt_q + 5'h1;
					if (cnt_q == len_q - 5'h1) begin
						cnt_d = '0;
						st_d  = ST_CMD;
						oe_d  = 1'b0;
						if (tgt_q == adc_port_pkg::REG_DATA) begin
							full_d = 1'b0;
						end
					end
				end
			end
			default: st_d = ST_CMD;
		endcase
		// held filter resync keeps the pipeline flushed
		if (setup_d[adc_port_pkg::SETUP_SYNC_BIT]) begin
			fres_d = 1'b1;
			full_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q    <= ST_CMD;
			sh_q    <= '0;
			cnt_q   <= '0;
			len_q   <= 5'(adc_port_pkg::BYTE_BITS);
			tgt_q   <= adc_port_pkg::REG_COMM;
			ch_q    <= '0;
			setup_q <= adc_port_pkg::SETUP_RST;
			clock_q <= adc_port_pkg::CLOCK_RST;
			data_q  <= '0;
			full_q  <= 1'b0;
			skip_q  <= '0;
			fres_q  <= 1'b1;
			cal_q   <= 1'b0;
			dout_q  <= 1'b1;
			oe_q    <= 1'b0;
		end else begin
			st_q    <= st_d;
			sh_q    <= sh_d;
			cnt_q   <= cnt_d;
			len_q   <= len_d;
			tgt_q   <= tgt_d;
			ch_q    <= ch_d;
			setup_q <= setup_d;
			clock_q <= clock_d;
			data_q  <= data_d;
			full_q  <= full_d;
			skip_q  <= skip_d;
			fres_q  <= fres_d;
			cal_q   <= cal_d;
			dout_q  <= dout_d;
			oe_q    <= oe_d;
		end
	end

	// outputs straight from flip-flops, except the ready pin, which is full_q inverted
	assign dout               = dout_q;
	assign dout_oe            = oe_q;
	assign conversion_ready_n = !full_q;
	assign active_channel     = ch_q;
	assign setup_reg          = setup_q;
	assign clock_reg          = clock_q;
	assign filter_reset       = fres_q;
	assign cal_start          = cal_q;

	////////////////////////////////////////////////////////////////
	// checks
	chk_ready_new_word: assert property (@(posedge core_clk) disable iff (srst)
		$fell(conversion_ready_n) |-> $past(fifo_pop) && data_q == $past(fifo_data))
		else $error("ready low without a new word");
	chk_resync_holds_ready: assert property (@(posedge core_clk) disable iff (srst)
		fres_q |-> conversion_ready_n) else $error("ready low during resync");
	chk_write_quiet_out: assert property (@(posedge core_clk) disable iff (srst)
		st_q == ST_WR |-> !dout_oe) else $error("output driven on write");
	chk_cmd_to_write: assert property (@(posedge core_clk) disable iff (srst)
		(st_q == ST_CMD && rise && cnt_q == 5'h7 && !byte_in[3] && byte_in[6:4] != 3'h0)
		|=> st_q == ST_WR) else $error("no write after command");
	chk_cmd_to_read: assert property (@(posedge core_clk) disable iff (srst)
		(st_q == ST_CMD && rise && cnt_q == 5'h7 && byte_in == 8'h38)
		|=> st_q == ST_RD && len_q == 5'd16 && dout_oe) else $error("no data read");
	chk_channel_latch: assert property (@(posedge core_clk) disable iff (srst)
		(st_q == ST_CMD && rise && cnt_q == 5'h7) |=> active_channel == $past(byte_in[1:0]))
		else $error("channel not taken");
	chk_setup_self_cal: assert property (@(posedge core_clk) disable iff (srst)
		(st_q == ST_WR && tgt_q == 3'h1 && rise && cnt_q == 5'h7 && byte_in == 8'h40)
		|=> cal_start && setup_reg == 8'h40 ##1 !cal_start) else $error("setup write");
	chk_clock_write: assert property (@(posedge core_clk) disable iff (srst)
		(st_q == ST_WR && tgt_q == 3'h2 && rise && cnt_q == 5'h7)
		|=> clock_reg == $past(byte_in) && st_q == ST_CMD) else $error("clock write");
	chk_back_to_cmd: assert property (@(posedge core_clk) disable iff (srst)
		(st_q == ST_RD && rise && cnt_q == len_q - 5'h1) |=> st_q == ST_CMD && !dout_oe)
		else $error("no return to command");
endmodule

//--- verif/host_master.sv
`timescale 1ns/1ps
// host end of the serial link: owns clock, select and data in, gathers read words
module host_master #(
	parameter int HALF = 8
) (
	input  wire logic   core_clk,
	output logic        sclk,
	output logic        cs_n,
	output logic        din,
	input  wire logic   dout,
	input  wire logic   dout_oe,
	output logic [15:0] rx_word,
	output logic        rx_stb,
	output logic        oe_in_wr
);
	// idle: clock high between frames, nothing selected
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		rx_word = 16'h0000;
		rx_stb = 1'b0;
		oe_in_wr = 1'b0;
	end
	////////////////////////////////////////
	// shifts n bits from the top of tx; one_cs keeps select low over the frame
	task shift(input logic [23:0] tx, input int n, input logic one_cs);
		logic [15:0] rx;
		rx = 16'h0000;
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			cs_n = 1'b0;
			sclk = 1'b0;
			din = tx[23 - i];
			repeat (HALF) @(negedge core_clk);
			sclk = 1'b1;
			// a released output reads as the inverse, so a late enable shows up
			rx = {rx[14:0], dout_oe ? dout : ~dout};
			if (!(n == 24 && i >= 8) && dout_oe !== 1'b0)
				oe_in_wr = 1'b1;
			repeat (HALF - 1) @(negedge core_clk);
			if (i % 8 == 7 && !one_cs) begin
				cs_n = 1'b1;
				din = ~din; // a released line must not keep its last level
				repeat (HALF) @(negedge core_clk);
			end
		end
		cs_n = 1'b1;
		if (n == 24) begin
			rx_word = rx;
			rx_stb = 1'b1;
			@(negedge core_clk);
			rx_stb = 1'b0;
		end
	endtask
	// command byte plus one register byte
	task wr(input logic [15:0] cmd_val, input logic one_cs);
		shift({cmd_val, 8'h00}, 16, one_cs);
	endtask
	// data read: command, then sixteen bits clocked out behind dummy bits
	task rd(input logic [15:0] dummy);
		shift({adc_port_pkg::CMD_DATA_RD, dummy}, 24, 1'b0);
	endtask
endmodule

//--- verif/adc_serial_port_bench.sv
`timescale 1ns/1ps
module adc_serial_port_bench;
	logic        core_clk;
	logic        srst;
	logic        sample_valid;
	logic [15:0] sample_data;
	logic        sclk;
	logic        cs_n;
	logic        din;
	logic        dout;
	logic        dout_oe;
	logic        conversion_ready_n;
	logic        sample_ready;
	logic [1:0]  active_channel;
	logic [7:0]  setup_reg;
	logic [7:0]  clock_reg;
	logic        filter_reset;
	logic        cal_start;
	logic [15:0] rx_word;
	logic        rx_stb;
	logic        oe_in_wr;
	logic [15:0] w;
	logic [15:0] exp_q[$];
	int          n_fail;
	int          checked;
	int          n_cal;
	int          seed;

	adc_serial_port #(.FIFO_W(16), .FIFO_D(adc_port_pkg::FIFO_DEPTH)) adc_serial_port_inst (
		.core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n),
		.sample_data(sample_data), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .active_channel(active_channel),
		.setup_reg(setup_reg), .clock_reg(clock_reg), .filter_reset(filter_reset),
		.cal_start(cal_start));
	host_master host_master_inst (
		.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .rx_word(rx_word), .rx_stb(rx_stb), .oe_in_wr(oe_in_wr));

	// 200 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////
	task final_report;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task tmo(input string what);
		n_fail++;
		$display("MISMATCH t=%0t timeout %s", $time, what);
		final_report;
	endtask
	// bounded poll of the ready pin, as the host would
	task wait_rdy;
		int k;
		k = 0;
		while (conversion_ready_n !== 1'b0) begin
			@(negedge core_clk);
			k++;
			if (k > 2000)
				tmo("ready");
		end
	endtask
	// valid held until the fifo shows room
	task push(input logic [15:0] v);
		int k;
		k = 0;
		@(negedge core_clk);
		sample_data = v;
		sample_valid = 1'b1;
		while (sample_ready !== 1'b1) begin
			@(negedge core_clk);
			k++;
			if (k > 200)
				tmo("push");
		end
		@(negedge core_clk);
		sample_valid = 1'b0;
		sample_data = ~v;
	endtask
	////////////////////////////////////////
	// each finished read takes the oldest noted word
	always @(posedge rx_stb) begin
		if (exp_q.size() == 0)
			tmo("unexpected read");
		else
			chk(rx_word, exp_q.pop_front(), "read word");
	end
	// count calibration starts
	always @(posedge core_clk) begin
		if (cal_start === 1'b1)
			n_cal++;
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		tmo("run");
	end
	// main sequence
	initial begin
		seed = 32'h9d9ea5a7;
		n_fail = 0;
		checked = 0;
		n_cal = 0;
		srst = 1'b1;
		sample_valid = 1'b0;
		sample_data = 16'h0000;
		repeat (10) @(negedge core_clk);
		srst = 1'b0;
		@(negedge core_clk);
		chk({setup_reg, clock_reg}, {adc_port_pkg::SETUP_RST, adc_port_pkg::CLOCK_RST},
			"reset regs");
		chk({11'h000, conversion_ready_n, dout_oe, filter_reset, active_channel},
			16'h0014, "reset pins");
		host_master_inst.wr({adc_port_pkg::CMD_CLOCK_WR, 8'h18}, 1'b1);
		repeat (20) @(negedge core_clk);
		chk({6'h00, active_channel, clock_reg}, 16'h0018, "clock write");
		host_master_inst.wr({adc_port_pkg::CMD_SETUP_WR, 8'h40}, 1'b0);
		repeat (20) @(negedge core_clk);
		chk({setup_reg, 7'h00, filter_reset}, 16'h4000, "setup write");
		chk(16'(n_cal), 16'h0001, "calibration");
		// first three words after calibration are dropped; then fill to refusal
		for (int i = 0; i < 12; i++) begin
			w = 16'($random(seed));
			if (i >= adc_port_pkg::SETTLE_UPDATES)
				exp_q.push_back(w);
			push(w);
			repeat (20) @(negedge core_clk);
		end
		chk({14'h0000, sample_ready, conversion_ready_n}, 16'h0000, "full");
		// drain; first read sends ones, which must be ignored
		for (int i = 0; i < 9; i++) begin
			wait_rdy;
			host_master_inst.rd(i == 0 ? 16'hffff : 16'h0000);
		end
		repeat (30) @(negedge core_clk);
		chk({14'h0000, conversion_ready_n, sample_ready}, 16'h0003, "drained");
		chk({15'h0000, oe_in_wr}, 16'h0000, "oe during write");
		// resync: filter held, ready stays high while samples arrive
		// resync bit alone: calibration field left at zero
		host_master_inst.wr({adc_port_pkg::CMD_SETUP_WR, 8'h01}, 1'b0);
		push(16'($random(seed)));
		repeat (40) @(negedge core_clk);
		chk({14'h0000, filter_reset, conversion_ready_n}, 16'h0003, "resync");
		chk(16'(n_cal), 16'h0001, "no extra calibration");
		// a channel other than the first, so a stuck channel field shows up
		host_master_inst.wr({adc_port_pkg::CMD_CLOCK_WR | 8'h02, 8'h18}, 1'b1);
		repeat (20) @(negedge core_clk);
		chk({6'h00, active_channel, clock_reg}, 16'h0218, "channel pick");
		final_report;
	end
endmodule
